// *** design/scr_pkg.sv ***
// Package of offsets, fields, reset values and timing for the sync and coast control bank
package scr_pkg;
  // ----------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_POL_SET   = 8'h0F;
  localparam logic [7:0] IDX_SYNC_CTRL = 8'h14;
  localparam logic [7:0] IDX_POL_RB    = 8'h15;
  localparam logic [7:0] IDX_SLICER    = 8'h16;
  localparam logic [7:0] IDX_LEAD      = 8'h17;
  localparam logic [7:0] IDX_TRAIL     = 8'h18;
  localparam logic [7:0] IDX_TEST      = 8'h19;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POS_HS_SET   = 7;
  localparam int POS_HS_OVR   = 0;
  localparam int POS_RB_HS    = 7;
  localparam int POS_RB_VS    = 6;
  localparam int POS_RB_CS    = 5;
  localparam int POS_THR_LSB  = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_POL_SET   = 8'h00;
  localparam logic [7:0] RST_SYNC_CTRL = 8'h00;
  localparam logic [4:0] RST_THRESH    = 5'h17;
  localparam logic [7:0] RST_LEAD      = 8'h00;
  localparam logic [7:0] RST_TRAIL     = 8'h00;
  localparam logic [7:0] RST_TEST      = 8'h00;

  // ----------------------------------------------------------------
  // Timing: polarity measurement window
  // ----------------------------------------------------------------
  localparam int CLK_MHZ      = 125;
  localparam int DET_WIN_MS   = 40;
  localparam int DET_WIN_CYC  = DET_WIN_MS * 1000 * CLK_MHZ;
endpackage

// *** design/scr_pol_detect.sv ***
// Polarity detector: decides which level of a sync input is the short active pulse
`timescale 1ns/1ps
`default_nettype none
module scr_pol_detect #(
  parameter int WIN_CYC = 5000000
) (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic sig_in,
  output var  logic active_high_r
);
  // ----------------------------------------------------------------
  // Window counter and level tallies
  // ----------------------------------------------------------------
  // Sync pulses are short, so the rarer level over a window is the active one
  logic [31:0] win_r;
  logic [31:0] high_r;
  logic [31:0] low_r;
  wire         win_end = (win_r == 32'(WIN_CYC - 1));

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      win_r         <= 32'h0000_0000;
      high_r        <= 32'h0000_0000;
      low_r         <= 32'h0000_0000;
      active_high_r <= 1'b1;
    end else if (win_end) begin
      win_r         <= 32'h0000_0000;
      high_r        <= 32'h0000_0000;
      low_r         <= 32'h0000_0000;
      active_high_r <= (high_r <= low_r); // Ties keep active high
    end else begin
      win_r  <= win_r + 32'h0000_0001;
      high_r <= high_r + {31'h0000_0000, sig_in};
      low_r  <= low_r + {31'h0000_0000, ~sig_in};
    end
  end
endmodule
`default_nettype wire

// *** design/scr_sync_coast_regs.sv ***
// Sync polarity and coast window control bank with a classic Wishbone slave
`timescale 1ns/1ps
`default_nettype none
module scr_sync_coast_regs
  import scr_pkg::*;
#(
  parameter int DET_CYC = DET_WIN_CYC,
  parameter int LINE_W  = 12
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  input  wire logic        hsync_in,
  input  wire logic        vsync_in,
  input  wire logic        coast_in,
  output var  logic        hsync_out,
  output var  logic        vsync_out,
  output var  logic        coast_out,
  output var  logic [4:0]  slicer_thresh,
  output var  logic [7:0]  test_value
);
  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] pol_set_r;
  logic [7:0] sync_ctrl_r;
  logic [2:0] slicer_low_r;
  logic [7:0] lead_r;
  logic [7:0] trail_r;
  logic       hs_det;
  logic       vs_det;
  logic       cs_det;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire       bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [7:0] idx     = {2'b00, wb_adr_i[7:2]};
  wire       wr_ok   = bus_req & wb_we_i & wb_sel_i[0];
  wire       wr_pol  = wr_ok & (idx == IDX_POL_SET);
  wire       wr_ctrl = wr_ok & (idx == IDX_SYNC_CTRL);
  wire       wr_slc  = wr_ok & (idx == IDX_SLICER);
  wire       wr_lead = wr_ok & (idx == IDX_LEAD);
  wire       wr_trl  = wr_ok & (idx == IDX_TRAIL);
  wire       wr_test = wr_ok & (idx == IDX_TEST);

  // Readback of live polarity state; vsync output bit reads 0 for active high
  wire [7:0] rb_val = {hs_det, ~vs_det, cs_det, 5'h00};

  // Read multiplexer; unmapped words read zero and still acknowledge
  logic [7:0] rd_byte;
  always_comb begin
    case (idx)
      IDX_POL_SET:   rd_byte = pol_set_r;
      IDX_SYNC_CTRL: rd_byte = sync_ctrl_r;
      IDX_POL_RB:    rd_byte = rb_val;
      IDX_SLICER:    rd_byte = {slicer_thresh, slicer_low_r};
      IDX_LEAD:      rd_byte = lead_r;
      IDX_TRAIL:     rd_byte = trail_r;
      IDX_TEST:      rd_byte = test_value;
      default:       rd_byte = 8'h00;
    endcase
  end

  // Single-wait-state answer: ack one edge after the request, then dropped
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  // Bit 2 of the slicer word is stored as written; software keeps it zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pol_set_r     <= RST_POL_SET;
      sync_ctrl_r   <= RST_SYNC_CTRL;
      slicer_thresh <= RST_THRESH;
      slicer_low_r  <= 3'h0;
      lead_r        <= RST_LEAD;
      trail_r       <= RST_TRAIL;
      test_value    <= RST_TEST;
    end else begin
      if (wr_pol)  pol_set_r <= wb_dat_i[7:0];
      if (wr_ctrl) sync_ctrl_r <= wb_dat_i[7:0];
      if (wr_slc) begin
        slicer_thresh <= wb_dat_i[7:POS_THR_LSB];
        slicer_low_r  <= wb_dat_i[2:0];
      end
      if (wr_lead) lead_r <= wb_dat_i[7:0];
      if (wr_trl)  trail_r <= wb_dat_i[7:0];
      if (wr_test) test_value <= wb_dat_i[7:0]; // Left at zero by software
    end
  end

  // ----------------------------------------------------------------
  // Polarity detection, one detector per sync input
  // ----------------------------------------------------------------
  logic [2:0] raw_in;
  logic [2:0] det_hi;
  assign raw_in = {coast_in, vsync_in, hsync_in};
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_det
      scr_pol_detect #(.WIN_CYC(DET_CYC)) u_det (
        .mclk          (mclk),
        .reset_n       (reset_n),
        .sig_in        (raw_in[g]),
        .active_high_r (det_hi[g])
      );
    end
  endgenerate
  assign hs_det = det_hi[0];
  assign vs_det = det_hi[1];
  assign cs_det = det_hi[2];

  // Hsync override picks the software polarity, otherwise the detected one; vsync and coast always use the detected one
  wire hs_ovr = sync_ctrl_r[POS_HS_OVR];
  wire hs_pol = hs_ovr ? pol_set_r[POS_HS_SET] : hs_det;
  wire hs_act = hsync_in ^ ~hs_pol;
  wire vs_act = vsync_in ^ ~vs_det;
  wire cs_act = coast_in ^ ~cs_det;

  // ----------------------------------------------------------------
  // Coast window from hsync edges around vsync
  // ----------------------------------------------------------------
  // Lead needs the next vsync ahead of time, so the last frame's line count
  // predicts it; the first frame after reset therefore has no lead part.
  // The stored length is the index of the last line, so lines left = len+1-lines.
  logic              hs_d_r;
  logic              vs_d_r;
  logic [LINE_W-1:0] lines_r;
  logic [LINE_W-1:0] frame_len_r;
  logic              frame_ok_r;
  logic              coast_win_r;
  wire               hs_edge = hs_act & ~hs_d_r;
  wire               vs_edge = vs_act & ~vs_d_r;
  wire [LINE_W:0]    lead_sum = {1'b0, lines_r} + (LINE_W+1)'(lead_r);
  wire               in_trail = (lines_r < LINE_W'(trail_r));
  wire               in_lead = frame_ok_r & (lead_r != 8'h00) &
                               (lead_sum > {1'b0, frame_len_r});
  wire               win_nxt = in_trail | in_lead;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hs_d_r      <= 1'b0;
      vs_d_r      <= 1'b0;
      lines_r     <= '1;
      frame_len_r <= '0;
      frame_ok_r  <= 1'b0;
      coast_win_r <= 1'b0;
    end else begin
      hs_d_r      <= hs_act;
      vs_d_r      <= vs_act;
      coast_win_r <= win_nxt;
      if (vs_edge) begin
        lines_r     <= '0;
        frame_len_r <= lines_r;
        frame_ok_r  <= 1'b1;
      end else if (hs_edge && lines_r != '1) begin
        lines_r <= lines_r + LINE_W'(1);
      end
    end
  end

  // Outputs: syncs re-issued active high, coast window merged with the coast pin
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hsync_out <= 1'b0;
      vsync_out <= 1'b0;
      coast_out <= 1'b0;
    end else begin
      hsync_out <= hs_act;
      vsync_out <= vs_act;
      coast_out <= coast_win_r | cs_act;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_rb_read;
    wb_ack_o && !wb_we_i && (idx == IDX_POL_RB);
  endsequence

  a_hpol_override: assert property (@(posedge mclk) disable iff (!reset_n)
    hs_ovr |-> (hs_pol == pol_set_r[POS_HS_SET]))
    else $error("hsync polarity ignores override setting");
  a_hpol_auto: assert property (@(posedge mclk) disable iff (!reset_n)
    !hs_ovr |-> (hs_pol == det_hi[0]))
    else $error("hsync polarity not from detector");
  a_rb_hsync_bit: assert property (@(posedge mclk) disable iff (!reset_n)
    s_rb_read |-> (wb_dat_o[POS_RB_HS] == $past(det_hi[0])))
    else $error("readback bit 7 wrong");
  a_rb_vsync_bit: assert property (@(posedge mclk) disable iff (!reset_n)
    s_rb_read |-> (wb_dat_o[POS_RB_VS] == !$past(det_hi[1])))
    else $error("readback bit 6 wrong");
  a_rb_coast_bit: assert property (@(posedge mclk) disable iff (!reset_n)
    s_rb_read |-> (wb_dat_o[POS_RB_CS] == $past(det_hi[2])))
    else $error("readback bit 5 wrong");
  a_slicer_write: assert property (@(posedge mclk) disable iff (!reset_n)
    wr_slc |=> (slicer_thresh == $past(wb_dat_i[7:3])))
    else $error("slicer threshold not written");
  a_trail_start: assert property (@(posedge mclk) disable iff (!reset_n)
    (vs_edge && trail_r != 8'h00 && !wr_trl) |-> ##2 coast_win_r)
    else $error("coast not active after vsync");
  a_coast_idle: assert property (@(posedge mclk) disable iff (!reset_n)
    (lead_r == 8'h00 && trail_r == 8'h00) [*2] |-> !coast_win_r)
    else $error("coast active with zero counts");
  a_coast_span: assert property (@(posedge mclk) disable iff (!reset_n)
    (vs_edge && in_lead && trail_r != 8'h00 && !wr_trl) |=> coast_win_r ##1 coast_win_r)
    else $error("coast window broken at vsync");
endmodule
`default_nettype wire

// *** verification/scr_sync_coast_regs_bench.sv ***
// Self-checking bench for the sync polarity and coast window control bank
`timescale 1ns/1ps
`default_nettype none
module scr_sync_coast_regs_bench;
  import scr_pkg::*;
  logic        mclk, reset_n, cyc, stb, we, coast_in, hpol;
  logic        hsync_in = 1'b0;
  logic        vsync_in = 1'b0;
  logic [7:0]  adr;
  logic [31:0] dat, wb_dat_o, rd;
  logic [3:0]  sel;
  logic        wb_ack_o, hsync_out, vsync_out, coast_out;
  logic [4:0]  slicer_thresh;
  logic [7:0]  test_value;
  int          n_errors, checks;
  int          line_q = 0;
  int          pos_q = 0;

  scr_sync_coast_regs #(.DET_CYC(64), .LINE_W(12)) u_scr_sync_coast_regs (
    .mclk(mclk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .hsync_in(hsync_in), .vsync_in(vsync_in), .coast_in(coast_in),
    .hsync_out(hsync_out), .vsync_out(vsync_out), .coast_out(coast_out),
    .slicer_thresh(slicer_thresh), .test_value(test_value));

  // ----------------------------------------------------------------
  // Clock, reset and free-running video timing
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Frames of 10 lines of 16 cycles; hsync active 2 cycles, vsync active all of line 0
  always @(posedge mclk) begin
    pos_q    <= (pos_q == 15) ? 0 : pos_q + 1;
    line_q   <= (pos_q != 15) ? line_q : (line_q == 9) ? 0 : line_q + 1;
    hsync_in <= ((pos_q == 15) || (pos_q == 0)) ? hpol : ~hpol;
    vsync_in <= (pos_q == 15) ? (line_q == 9) : (line_q == 0);
  end
  // Hang guard, sized well past the expected run
  initial begin
    #160000;
    n_errors++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Classic cycle: hold until ack is sampled, then release for at least one cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    @(posedge mclk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h000000, d}; sel <= s;
    do @(posedge mclk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic wait_at(input int ln, input int ps);
    do begin
      @(posedge mclk);
      #1;
    end while (!(line_q == ln && pos_q == ps));
  endtask
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic reset_values();
    wb(1'b0, 8'h54, 8'h00, 4'hF, rd); chk(rd, 32'h000000A0);
    wb(1'b0, 8'h58, 8'h00, 4'hF, rd); chk(rd[7:3], 5'h17);
    wb(1'b0, 8'h5C, 8'h00, 4'hF, rd); chk(rd, 32'h0);
    wb(1'b0, 8'h60, 8'h00, 4'hF, rd); chk(rd, 32'h0);
    wb(1'b0, 8'h64, 8'h00, 4'hF, rd); chk(rd, 32'h0);
    chk(slicer_thresh, 5'h17);
    chk(test_value, 8'h00);
    wait_at(9, 8); chk(coast_out, 1'b0);
  endtask
  task automatic slicer_access();
    wb(1'b1, 8'h58, 8'h48, 4'hF, rd);
    chk(slicer_thresh, 5'h09);
    wb(1'b1, 8'h58, 8'hF8, 4'h0, rd);
    wb(1'b0, 8'h58, 8'h00, 4'hF, rd); chk(rd, 32'h00000048);
    wb(1'b1, 8'h54, 8'h00, 4'hF, rd);
    wb(1'b0, 8'h54, 8'h00, 4'hF, rd); chk(rd, 32'h000000A0);
    wb(1'b0, 8'h80, 8'h00, 4'hF, rd); chk(rd, 32'h0);
    wb(1'b1, 8'h64, 8'h00, 4'hF, rd); chk(test_value, 8'h00);
  endtask
  task automatic hsync_polarity();
    hpol <= 1'b0;
    repeat (3) wait_at(0, 8);
    wb(1'b0, 8'h54, 8'h00, 4'hF, rd); chk(rd, 32'h00000020);
    wait_at(3, 2); chk(hsync_out, 1'b1);
    wait_at(3, 8); chk(hsync_out, 1'b0);
    wb(1'b1, 8'h3C, 8'h80, 4'hF, rd);
    wb(1'b1, 8'h50, 8'h11, 4'hF, rd);
    wait_at(3, 2); chk(hsync_out, 1'b0);
    wait_at(3, 8); chk(hsync_out, 1'b1);
    wb(1'b0, 8'h54, 8'h00, 4'hF, rd); chk(rd[7], 1'b0);
    wb(1'b1, 8'h50, 8'h10, 4'hF, rd);
    wait_at(3, 2); chk(hsync_out, 1'b1);
  endtask
  task automatic coast_window();
    wb(1'b1, 8'h5C, 8'h02, 4'hF, rd);
    wb(1'b1, 8'h60, 8'h03, 4'hF, rd);
    wb(1'b0, 8'h5C, 8'h00, 4'hF, rd); chk(rd, 32'h00000002);
    wb(1'b0, 8'h60, 8'h00, 4'hF, rd); chk(rd, 32'h00000003);
    repeat (2) wait_at(0, 8);
    wait_at(0, 8); chk(vsync_out, 1'b1);
    wait_at(1, 8); chk(coast_out, 1'b1);
    wait_at(2, 8); chk(coast_out, 1'b1);
    wait_at(5, 8); chk(coast_out, 1'b0);
    wait_at(7, 8); chk(coast_out, 1'b0);
    wait_at(8, 8); chk(coast_out, 1'b1);
    wait_at(9, 8); chk(coast_out, 1'b1);
    // Coast pin held high reads back as active low and no longer opens the window
    @(posedge mclk);
    coast_in <= 1'b1;
    repeat (2) wait_at(5, 8);
    chk(coast_out, 1'b0);
    wb(1'b0, 8'h54, 8'h00, 4'hF, rd); chk(rd, 32'h00000000);
  endtask

  // Main sequence
  initial begin
    reset_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; dat = 32'h0;
    sel = 4'h0; coast_in = 1'b0; hpol = 1'b1;
    n_errors = 0; checks = 0;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    reset_values();
    slicer_access();
    hsync_polarity();
    coast_window();
    complete_run();
  end
endmodule
`default_nettype wire
